/* core/scsi_status_sense_tracker.v */
`timescale 1ns/1ps
`include "status_sense_defines.vh"
// How it works
// - Every command not dropped by a reset, nor arriving in a completion cycle, ends with one status byte.
// - Status byte: code in bits four to one.
// - Good, or intermediate when linked command succeeds.
// - Check condition always enters pending with sense.
// - Recovered error key still means command succeeded.
// - Reject bad LUN, CDB, attention, transfer fault.
// - Busy while executing or loading drive information.
// - Reserved elsewhere: conflict, except sense, inquiry, release.
// - Bus failure also enters pending; extended sense only.
// - Pending kept per initiator; others run normally.
// - Owner command that runs, except no-op, clears pending state.
// - Abort from owner discards its sense.
// - Owner addressing another LUN gets busy.
// - Invalid LUN becomes the pending LUN.
// - New error while pending builds fresh sense.
// - Bus reset or device reset clears pending state and running command, sets attention.
// - Unidentified initiator uses the anonymous slot.
// - Record has validity flag and error code 70h.
// - Length mismatch flag only for long read/write.
// - Information holds block address or length difference.
// - Additional length always reads 28h.
// - Command specific field only for block reassign.
// - Unit attention clears once reported as check.
module scsi_status_sense_tracker (
  input wire mclk,
  input wire reset,
  input wire [2:0] targetId,
  input wire reqValid,
  input wire reqIdValid,
  input wire [2:0] reqId,
  input wire [2:0] reqLun,
  input wire [7:0] reqOpcode,
  input wire reqLink,
  input wire lunValid,
  input wire cdbError,
  input wire xferHwError,
  input wire reservedByOther,
  input wire loadingInfo,
  input wire cmdDone,
  input wire doneError,
  input wire [3:0] doneKey,
  input wire [7:0] doneCode,
  input wire doneInfoValid,
  input wire [31:0] doneLba,
  input wire [15:0] doneReqLen,
  input wire [15:0] doneBlkLen,
  input wire [31:0] doneCmdSpecific,
  input wire abortMsg,
  input wire abortIdValid,
  input wire [2:0] abortId,
  input wire busResetCond,
  input wire devResetMsg,
  input wire busFail,
  input wire busFailIdValid,
  input wire [2:0] busFailId,
  input wire [2:0] busFailLun,
  input wire readyAttn,
  input wire modeChanged,
  input wire [2:0] modeChangerId,
  input wire [5:0] senseIdx,
  output reg statusValid_reg,
  output reg [7:0] statusByte_reg,
  output reg cmdSuccess_reg,
  output reg execStart_reg,
  output reg [7:0] execOp_reg,
  output reg [2:0] execLun_reg,
  output reg [3:0] execSlot_reg,
  output reg execActive_reg,
  output reg [7:0] senseByte_reg,
  output reg [8:0] pendValid_reg,
  output reg [7:0] unitAttn_reg
);
  // Per-slot pending LUN and retained sense fields, indexed by slot.
  reg [2:0] pendLun_reg [0:8];
  reg [3:0] keyMem_reg [0:8];
  reg [7:0] codeMem_reg [0:8];
  reg [31:0] infoMem_reg [0:8];
  reg [31:0] csiMem_reg [0:8];
  reg [8:0] infoOk_reg;
  reg [8:0] lenMisMem_reg;
  // Snapshot handed out by a sense request, so clearing the slot is safe.
  reg snapValid_reg;
  reg snapLenMis_reg;
  reg [3:0] snapKey_reg;
  reg [7:0] snapCode_reg;
  reg [31:0] snapInfo_reg;
  reg [31:0] snapCsi_reg;
  reg [2:0] snapLun_reg;
  // Link request of the command now running.
  reg execLink_reg;
  // Request decision, settled combinationally from the current request.
  reg [3:0] reqSlot;
  reg [7:0] decStatus;
  reg decReject;
  reg decCheck;
  reg [3:0] decKey;
  reg [7:0] decCode;
  reg decExec;
  reg reqAttn;
  reg isSense;
  reg isInq;
  // Completion sense fields, built from the executor report.
  reg [31:0] doneInfo;
  reg doneLenMis;
  reg doneLong;
  reg [15:0] lenDiff;
  reg [3:0] failSlot;
  reg [3:0] abortSlot;
  wire [7:0] fmtByte;
  integer i;

  // Anonymous selections share one slot apart from the eight identities.
  function [3:0] slotOf;
    input idKnown;
    input [2:0] id;
    begin
      slotOf = idKnown ? {1'b0, id} : `ANON_SLOT;
    end
  endfunction

  // Decide the answer to a new request, in priority order.
  always @* begin
    reqSlot = slotOf(reqIdValid, reqId);
    isSense = (reqOpcode == `OP_REQ_SENSE);
    isInq = (reqOpcode == `OP_INQUIRY);
    reqAttn = reqIdValid & unitAttn_reg[reqId];
    decStatus = `ST_GOOD;
    decReject = 1'b1;
    decCheck = 1'b0;
    decKey = `KEY_NONE;
    decCode = 8'h00;
    decExec = 1'b0;
    if (execActive_reg || loadingInfo) begin
      // One command at a time; new ones wait out setup too.
      decStatus = `ST_BUSY;
    end else if (pendValid_reg[reqSlot] && pendLun_reg[reqSlot] != reqLun) begin
      // Owner must come back to its pending LUN first.
      decStatus = `ST_BUSY;
    end else if (!lunValid && !isInq) begin
      // The bad LUN itself becomes the pending LUN below.
      decCheck = 1'b1;
      decKey = `KEY_ILLEGAL;
      decCode = `CODE_BAD_LUN;
    end else if (reqAttn && !isSense && !isInq && reqOpcode != `OP_PRIO_RESERVE) begin
      decCheck = 1'b1;
      decKey = `KEY_UNIT_ATTN;
      decCode = `CODE_UNIT_ATTN;
    end else if (cdbError) begin
      decCheck = 1'b1;
      decKey = `KEY_ILLEGAL;
      decCode = `CODE_BAD_CDB;
    end else if (xferHwError) begin
      decCheck = 1'b1;
      decKey = `KEY_HARDWARE;
      decCode = `CODE_BUS_FAIL;
    end else if (reservedByOther && !isSense && !isInq) begin
      // A release from a non-holder is swallowed and simply reported good.
      if (reqOpcode != `OP_RELEASE) begin
        decStatus = `ST_CONFLICT;
      end
    end else begin
      decReject = 1'b0;
      decExec = 1'b1;
    end
    if (decCheck) begin
      decStatus = `ST_CHECK;
    end
  end

  // Build completion sense: the length difference only for long transfers.
  always @* begin
    doneLong = (execOp_reg == `OP_READ_LONG) || (execOp_reg == `OP_WRITE_LONG);
    doneLenMis = doneLong && (doneReqLen != doneBlkLen);
    lenDiff = doneReqLen - doneBlkLen;
    if (doneLenMis) begin
      // Sign-extend so a short request reads as a two's complement value.
      doneInfo = {{16{lenDiff[15]}}, lenDiff};
    end else begin
      doneInfo = doneLba;
    end
    failSlot = slotOf(busFailIdValid, busFailId);
    abortSlot = slotOf(abortIdValid, abortId);
  end

  // Format the byte the sense reader currently points at.
  sense_byte_format i_sense_byte_format (
    .infoValid(snapValid_reg),
    .lengthMismatchFlag(snapLenMis_reg),
    .senseKey(snapKey_reg),
    .senseCode(snapCode_reg),
    .info(snapInfo_reg),
    .cmdSpecific(snapCsi_reg),
    .lun(snapLun_reg),
    .targetId(targetId),
    .byteIdx(senseIdx),
    .senseByte(fmtByte)
  );

  // Status reporting and the execution hand-off.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      statusValid_reg <= 1'b0;
      statusByte_reg <= 8'h00;
      cmdSuccess_reg <= 1'b0;
      execStart_reg <= 1'b0;
      execOp_reg <= 8'h00;
      execLun_reg <= 3'h0;
      execSlot_reg <= 4'h0;
      execActive_reg <= 1'b0;
      execLink_reg <= 1'b0;
      senseByte_reg <= 8'h00;
    end else begin
      statusValid_reg <= 1'b0;
      execStart_reg <= 1'b0;
      senseByte_reg <= fmtByte;
      if (busResetCond || devResetMsg) begin
        // A reset drops the running command without a status byte.
        execActive_reg <= 1'b0;
      end else if (cmdDone && execActive_reg) begin
        // Each completed command closes with exactly one status byte.
        execActive_reg <= 1'b0;
        statusValid_reg <= 1'b1;
        if (doneError) begin
          statusByte_reg <= `ST_CHECK;
          cmdSuccess_reg <= (doneKey == `KEY_RECOVERED);
        end else begin
          statusByte_reg <= execLink_reg ? `ST_INTERMEDIATE : `ST_GOOD;
          cmdSuccess_reg <= 1'b1;
        end
      end else if (reqValid) begin
        if (decReject) begin
          statusValid_reg <= 1'b1;
          statusByte_reg <= decStatus;
          cmdSuccess_reg <= (decStatus == `ST_GOOD);
        end else begin
          execStart_reg <= 1'b1;
          execActive_reg <= 1'b1;
          execOp_reg <= reqOpcode;
          execLun_reg <= reqLun;
          execSlot_reg <= reqSlot;
          execLink_reg <= reqLink;
        end
      end
    end
  end

  // Pending state and retained sense per slot, unit attention per identified initiator.
  // Clears are applied first so a same-cycle bus failure or rejected request always survives.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pendValid_reg <= 9'h000;
      infoOk_reg <= 9'h000;
      lenMisMem_reg <= 9'h000;
      unitAttn_reg <= 8'hff;
      for (i = 0; i < `NSLOT; i = i + 1) begin
        pendLun_reg[i] <= 3'h0;
        keyMem_reg[i] <= 4'h0;
        codeMem_reg[i] <= 8'h00;
        infoMem_reg[i] <= 32'h00000000;
        csiMem_reg[i] <= 32'h00000000;
      end
      snapValid_reg <= 1'b0;
      snapLenMis_reg <= 1'b0;
      snapKey_reg <= 4'h0;
      snapCode_reg <= 8'h00;
      snapInfo_reg <= 32'h00000000;
      snapCsi_reg <= 32'h00000000;
      snapLun_reg <= 3'h0;
    end else begin
      if (busResetCond || devResetMsg) begin
        pendValid_reg <= 9'h000;
      end
      if (abortMsg) begin
        pendValid_reg[abortSlot] <= 1'b0;
      end
      if (reqValid && !execActive_reg && decExec) begin
        if (reqOpcode != `OP_NO_OP) begin
          pendValid_reg[reqSlot] <= 1'b0;
        end
        if (reqOpcode == `OP_PRIO_RESERVE && reqIdValid) begin
          unitAttn_reg[reqId] <= 1'b0;
        end
        if (isSense) begin
          // Hand out what is retained, or attention, or an empty record.
          snapLun_reg <= reqLun;
          snapCsi_reg <= csiMem_reg[reqSlot];
          snapInfo_reg <= infoMem_reg[reqSlot];
          if (pendValid_reg[reqSlot]) begin
            snapValid_reg <= infoOk_reg[reqSlot];
            snapLenMis_reg <= lenMisMem_reg[reqSlot];
            snapKey_reg <= keyMem_reg[reqSlot];
            snapCode_reg <= codeMem_reg[reqSlot];
          end else begin
            snapValid_reg <= 1'b0;
            snapLenMis_reg <= 1'b0;
            snapKey_reg <= reqAttn ? `KEY_UNIT_ATTN : `KEY_NONE;
            snapCode_reg <= reqAttn ? `CODE_UNIT_ATTN : 8'h00;
            snapCsi_reg <= 32'h00000000;
            snapInfo_reg <= 32'h00000000;
            if (reqAttn) begin
              unitAttn_reg[reqId] <= 1'b0;
            end
          end
        end
      end
      if (busFail) begin
        // Forced bus-free still leaves sense to collect.
        pendValid_reg[failSlot] <= 1'b1;
        pendLun_reg[failSlot] <= busFailLun;
        keyMem_reg[failSlot] <= `KEY_ABORTED;
        codeMem_reg[failSlot] <= `CODE_BUS_FAIL;
        infoOk_reg[failSlot] <= 1'b0;
        lenMisMem_reg[failSlot] <= 1'b0;
        infoMem_reg[failSlot] <= 32'h00000000;
        csiMem_reg[failSlot] <= 32'h00000000;
      end
      if (reqValid && !execActive_reg && decCheck) begin
        // Fresh sense replaces any older record for this slot.
        pendValid_reg[reqSlot] <= 1'b1;
        pendLun_reg[reqSlot] <= reqLun;
        keyMem_reg[reqSlot] <= decKey;
        codeMem_reg[reqSlot] <= decCode;
        infoOk_reg[reqSlot] <= 1'b0;
        lenMisMem_reg[reqSlot] <= 1'b0;
        infoMem_reg[reqSlot] <= 32'h00000000;
        csiMem_reg[reqSlot] <= 32'h00000000;
        if (decKey == `KEY_UNIT_ATTN) begin
          unitAttn_reg[reqId] <= 1'b0;
        end
      end
      if (cmdDone && execActive_reg && doneError && !busResetCond && !devResetMsg) begin
        pendValid_reg[execSlot_reg] <= 1'b1;
        pendLun_reg[execSlot_reg] <= execLun_reg;
        keyMem_reg[execSlot_reg] <= doneKey;
        codeMem_reg[execSlot_reg] <= doneCode;
        infoOk_reg[execSlot_reg] <= doneInfoValid | doneLenMis;
        lenMisMem_reg[execSlot_reg] <= doneLenMis;
        infoMem_reg[execSlot_reg] <= doneInfo;
        if (execOp_reg == `OP_REASSIGN) begin
          csiMem_reg[execSlot_reg] <= doneCmdSpecific;
        end else begin
          csiMem_reg[execSlot_reg] <= 32'h00000000;
        end
      end
      // Attention sets come last, so a report in the same cycle cannot swallow a new one.
      if (readyAttn || busResetCond || devResetMsg) begin
        unitAttn_reg <= 8'hff;
      end
      if (modeChanged) begin
        // Everyone but the initiator that changed the block size is told.
        for (i = 0; i < 8; i = i + 1) begin
          if (modeChangerId != i[2:0]) begin
            unitAttn_reg[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* core/sense_byte_format.v */
`timescale 1ns/1ps
`include "status_sense_defines.vh"
// Picks one byte of the 48-byte extended sense record from the stored fields.
module sense_byte_format (
  input wire infoValid,
  input wire lengthMismatchFlag,
  input wire [3:0] senseKey,
  input wire [7:0] senseCode,
  input wire [31:0] info,
  input wire [31:0] cmdSpecific,
  input wire [2:0] lun,
  input wire [2:0] targetId,
  input wire [5:0] byteIdx,
  output reg [7:0] senseByte
);
  // Unlisted bytes, and anything past the record end, read as zero.
  always @* begin
    senseByte = 8'h00;
    case (byteIdx)
      `SB_ERR: senseByte = {infoValid, `SENSE_ERR_CODE};
      `SB_KEY: senseByte = {2'b00, lengthMismatchFlag, 1'b0, senseKey};
      6'd3: senseByte = info[31:24];
      6'd4: senseByte = info[23:16];
      6'd5: senseByte = info[15:8];
      6'd6: senseByte = info[7:0];
      `SB_ADDLEN: senseByte = `SENSE_ADD_LEN;
      6'd8: senseByte = cmdSpecific[31:24];
      6'd9: senseByte = cmdSpecific[23:16];
      6'd10: senseByte = cmdSpecific[15:8];
      6'd11: senseByte = cmdSpecific[7:0];
      `SB_CODE: senseByte = senseCode;
      `SB_TID: senseByte = {5'h00, targetId};
      `SB_LUN: senseByte = {5'h00, lun};
      default: senseByte = 8'h00;
    endcase
  end
endmodule

/* core/status_sense_defines.vh */
`ifndef STATUS_SENSE_DEFINES_VH
`define STATUS_SENSE_DEFINES_VH
// Completion status bytes: code in bits 4..1, all other bits zero.
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define ST_BUSY 8'h08
`define ST_INTERMEDIATE 8'h10
`define ST_CONFLICT 8'h18
// Command opcodes the tracker has to recognise.
`define OP_REQ_SENSE 8'h03
`define OP_INQUIRY 8'h12
`define OP_RELEASE 8'h17
`define OP_REASSIGN 8'h07
`define OP_READ_LONG 8'h3e
`define OP_WRITE_LONG 8'h3f
`define OP_NO_OP 8'hc0
`define OP_PRIO_RESERVE 8'hc1
// Sense keys.
`define KEY_NONE 4'h0
`define KEY_RECOVERED 4'h1
`define KEY_HARDWARE 4'h4
`define KEY_ILLEGAL 4'h5
`define KEY_UNIT_ATTN 4'h6
`define KEY_ABORTED 4'hb
// Sense codes used for rejected requests and bus failures.
`define CODE_BAD_CDB 8'h24
`define CODE_BAD_LUN 8'h25
`define CODE_UNIT_ATTN 8'h29
`define CODE_BUS_FAIL 8'h47
// Extended sense record layout.
`define SENSE_ERR_CODE 7'h70
`define SENSE_ADD_LEN 8'h28
`define SENSE_BYTES 6'd48
`define SB_ERR 6'd0
`define SB_KEY 6'd2
`define SB_INFO0 6'd3
`define SB_INFO3 6'd6
`define SB_ADDLEN 6'd7
`define SB_CSI0 6'd8
`define SB_CSI3 6'd11
`define SB_CODE 6'd12
`define SB_TID 6'd14
`define SB_LUN 6'd15
`define KEY_LEN_MIS_BIT 5
// Eight identified initiators plus one anonymous slot.
`define NSLOT 9
`define ANON_SLOT 4'd8
`endif

/* tb/exec_partner_model.sv */
`timescale 1ns/1ps
// Stands in for the command executor: ends each started command after lat cycles.
module exec_partner_model (
  input wire mclk,
  input wire reset,
  input wire execStart_reg,
  input wire [7:0] lat,
  input wire [109:0] cfg,
  output reg cmdDone,
  output wire [109:0] doneBus
);
  reg [7:0] cnt_reg; // Cycles left until the command ends.
  // Outside the done pulse the fields carry junk, so a late sample shows up.
  assign doneBus = cmdDone ? cfg : ~cfg;
  // Reloads on every start pulse and raises done for exactly one cycle.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 8'h00;
      cmdDone <= 1'b0;
    end else begin
      cmdDone <= cnt_reg == 8'h01;
      if (execStart_reg) begin
        cnt_reg <= lat;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule

/* tb/scsi_status_sense_tracker_bench.sv */
`timescale 1ns/1ps
`include "status_sense_defines.vh"
// Plays several initiators against the tracker and checks status and sense bytes.
module scsi_status_sense_tracker_bench;
  logic mclk, reset, reqValid, reqIdValid, reqLink, lunValid, cdbError, xferHwError;
  logic reservedByOther, loadingInfo, abortMsg, abortIdValid, busResetCond, devResetMsg;
  logic busFail, busFailIdValid, readyAttn, modeChanged;
  logic [2:0] targetId, reqId, reqLun, abortId, busFailId, busFailLun, modeChangerId;
  logic [7:0] reqOpcode, lat;
  logic [5:0] senseIdx;
  logic [109:0] cfg; // Completion fields the executor hands back.
  logic [31:0] lfsrState; // Random source, also used as the failing block address.
  logic [8:0] expQ[$]; // Expected {success, status byte}, oldest first.
  logic [7:0] ops[3] = '{8'h08, `OP_READ_LONG, `OP_REASSIGN};
  int num_errors = 0, tests_run = 0, cyc = 0;
  wire cmdDone, doneError, doneInfoValid, statusValid_reg, cmdSuccess_reg;
  wire execStart_reg, execActive_reg;
  wire [3:0] doneKey, execSlot_reg;
  wire [7:0] doneCode, statusByte_reg, execOp_reg, senseByte_reg, unitAttn_reg;
  wire [31:0] doneLba, doneCmdSpecific;
  wire [15:0] doneReqLen, doneBlkLen;
  wire [2:0] execLun_reg;
  wire [8:0] pendValid_reg;
  wire [109:0] doneBus;
  assign {doneError, doneKey, doneCode, doneInfoValid, doneLba, doneReqLen, doneBlkLen,
    doneCmdSpecific} = doneBus;
  scsi_status_sense_tracker i_scsi_status_sense_tracker (.mclk, .reset, .targetId,
    .reqValid, .reqIdValid, .reqId, .reqLun, .reqOpcode, .reqLink, .lunValid, .cdbError,
    .xferHwError, .reservedByOther, .loadingInfo, .cmdDone, .doneError, .doneKey,
    .doneCode, .doneInfoValid, .doneLba, .doneReqLen, .doneBlkLen, .doneCmdSpecific,
    .abortMsg, .abortIdValid, .abortId, .busResetCond, .devResetMsg, .busFail,
    .busFailIdValid, .busFailId, .busFailLun, .readyAttn, .modeChanged, .modeChangerId,
    .senseIdx, .statusValid_reg, .statusByte_reg, .cmdSuccess_reg, .execStart_reg,
    .execOp_reg, .execLun_reg, .execSlot_reg, .execActive_reg, .senseByte_reg,
    .pendValid_reg, .unitAttn_reg);
  exec_partner_model i_exec_partner_model (.mclk, .reset, .execStart_reg, .lat, .cfg,
    .cmdDone, .doneBus);
  // Free-running clock, 4 ns period.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Shift register step; a fixed start keeps every run the same.
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compares one result and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits, bounded, for the status pulse of the request in flight.
  task automatic waitStat;
    int n;
    n = 0;
    @(posedge mclk);
    while (statusValid_reg !== 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    if (n == 100) chk("status wait", 1, 0);
  endtask
  // One request pulse; id 8 means no initiator ID was given at selection.
  task automatic req(input logic [3:0] id, input logic [2:0] lun, input logic [7:0] op,
      input logic lnk, input logic [7:0] e, input bit wt);
    reqValid <= 1'b1;
    reqIdValid <= !id[3];
    reqId <= id[2:0];
    reqLun <= lun;
    reqOpcode <= op;
    reqLink <= lnk;
    if (wt) expQ.push_back({e == `ST_GOOD || e == `ST_INTERMEDIATE, e});
    @(posedge mclk);
    reqValid <= 1'b0;
    if (wt) waitStat;
  endtask
  // Reads one byte of the latest sense snapshot.
  task automatic sense(input logic [5:0] i, input logic [7:0] e);
    senseIdx <= i;
    repeat (2) @(posedge mclk);
    chk("sense byte", e, senseByte_reg);
  endtask
  // Pulses one event: 0 abort, 1 bus reset, 2 bus failure, 3 mode change, 4 device reset.
  task automatic ev(input int k);
    {abortMsg, busResetCond, busFail, modeChanged, devResetMsg} <= 5'h10 >> k;
    @(posedge mclk);
    {abortMsg, busResetCond, busFail, modeChanged, devResetMsg} <= 5'h00;
    repeat (2) @(posedge mclk);
  endtask
  // Prints the verdict and ends the run.
  task automatic results;
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Every status pulse takes the oldest expectation off the queue.
  always @(posedge mclk) begin
    if (statusValid_reg === 1'b1) begin
      chk("status", expQ.pop_front(), {cmdSuccess_reg, statusByte_reg});
    end
  end
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results;
    end
  end
  // Main sequence.
  initial begin
    {reset, lunValid} = 2'h3;
    {reqValid, reqIdValid, reqLink, cdbError, xferHwError, reservedByOther} = 6'h00;
    {loadingInfo, abortMsg, abortIdValid, busResetCond, devResetMsg, busFail} = 6'h00;
    {busFailIdValid, readyAttn, modeChanged} = 3'h0;
    {targetId, reqId, reqLun, abortId, busFailId, busFailLun, modeChangerId} = 21'h5;
    {reqOpcode, lat, senseIdx, cfg} = '0;
    lfsrState = nextRand(32'h0001708f);
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    lat <= 8'h01;
    @(posedge mclk);
    req(4'h1, 3'h0, 8'h08, 1'b0, `ST_CHECK, 1'b1);
    req(4'h1, 3'h0, `OP_REQ_SENSE, 1'b0, `ST_GOOD, 1'b1);
    sense(`SB_KEY, {4'h0, `KEY_UNIT_ATTN});
    sense(`SB_CODE, `CODE_UNIT_ATTN);
    for (int i = 0; i < 8; i++) req(4'(i), 3'h0, `OP_REQ_SENSE, 1'b0, `ST_GOOD, 1'b1);
    chk("attention", 8'h00, unitAttn_reg);
    req(4'h2, 3'h0, 8'h08, 1'b0, `ST_GOOD, 1'b1);
    req(4'h2, 3'h0, 8'h08, 1'b1, `ST_INTERMEDIATE, 1'b1);
    loadingInfo <= 1'b1;
    req(4'h3, 3'h0, 8'h08, 1'b0, `ST_BUSY, 1'b1);
    loadingInfo <= 1'b0;
    lat <= 8'h14;
    req(4'h0, 3'h0, 8'h08, 1'b0, 8'h00, 1'b0);
    repeat (3) @(posedge mclk);
    req(4'h3, 3'h0, 8'h08, 1'b0, `ST_BUSY, 1'b1);
    expQ.push_back({1'b1, `ST_GOOD});
    waitStat;
    lat <= 8'h01;
    // A recovered error leaves slot 2 pending on unit 0.
    cfg <= {1'b1, `KEY_RECOVERED, 8'h17, 1'b1, lfsrState, 64'h0};
    req(4'h2, 3'h0, 8'h08, 1'b0, 8'h00, 1'b0);
    expQ.push_back({1'b1, `ST_CHECK});
    waitStat;
    cfg <= '0;
    req(4'h2, 3'h1, 8'h08, 1'b0, `ST_BUSY, 1'b1);
    req(4'h4, 3'h1, 8'h08, 1'b0, `ST_GOOD, 1'b1);
    req(4'h2, 3'h0, `OP_NO_OP, 1'b0, `ST_GOOD, 1'b1);
    chk("pending", 1'b1, pendValid_reg[2]);
    req(4'h2, 3'h0, 8'h00, 1'b0, `ST_GOOD, 1'b1);
    chk("pending", 1'b0, pendValid_reg[2]);
    // Ordinary, long and reassign failures; lengths differ, but only the long one flags it.
    for (int k = 0; k < 3; k++) begin
      cfg <= {1'b1, `KEY_HARDWARE, 8'h11, 1'b1, lfsrState, 64'h0100_0107_ca00_0000};
      req(4'h5, 3'h2, ops[k], 1'b0, `ST_CHECK, 1'b1);
      cfg <= '0;
      req(4'h5, 3'h2, `OP_REQ_SENSE, 1'b0, `ST_GOOD, 1'b1);
      sense(`SB_KEY, k == 1 ? 8'h24 : 8'h04);
      sense(`SB_CSI0, k == 2 ? 8'hca : 8'h00);
      sense(`SB_ERR, 8'hf0);
      for (int b = 0; b < 4; b++)
        sense(6'(3 + b), 8'((k == 1 ? 32'hfffffff9 : lfsrState) >> (24 - 8 * b)));
    end
    lunValid <= 1'b0;
    req(4'h8, 3'h5, 8'h08, 1'b0, `ST_CHECK, 1'b1);
    chk("pending", 1'b1, pendValid_reg[8]);
    req(4'h8, 3'h1, 8'h08, 1'b0, `ST_BUSY, 1'b1);
    req(4'h6, 3'h5, `OP_INQUIRY, 1'b0, `ST_GOOD, 1'b1);
    req(4'h8, 3'h5, `OP_INQUIRY, 1'b0, `ST_GOOD, 1'b1);
    chk("pending", 1'b0, pendValid_reg[8]);
    chk("exec", {4'h8, 3'h5, 8'h12}, {execSlot_reg, execLun_reg, execOp_reg});
    lunValid <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      {cdbError, xferHwError} <= 2'h2 >> k;
      req(4'h7, 3'h0, 8'h08, 1'b0, `ST_CHECK, 1'b1);
      {cdbError, xferHwError} <= 2'h0;
      req(4'h7, 3'h0, `OP_REQ_SENSE, 1'b0, `ST_GOOD, 1'b1);
      sense(`SB_CODE, k == 0 ? `CODE_BAD_CDB : `CODE_BUS_FAIL);
    end
    reservedByOther <= 1'b1;
    req(4'h3, 3'h0, 8'h08, 1'b0, `ST_CONFLICT, 1'b1);
    req(4'h3, 3'h0, `OP_RELEASE, 1'b0, `ST_GOOD, 1'b1);
    req(4'h3, 3'h0, `OP_INQUIRY, 1'b0, `ST_GOOD, 1'b1);
    reservedByOther <= 1'b0;
    {busFailIdValid, busFailId, abortIdValid, abortId} <= 8'hcc;
    ev(2);
    chk("pending", 1'b1, pendValid_reg[4]);
    ev(0);
    chk("pending", 1'b0, pendValid_reg[4]);
    ev(3);
    chk("attention", 8'hdf, unitAttn_reg);
    req(4'h3, 3'h0, `OP_PRIO_RESERVE, 1'b0, `ST_GOOD, 1'b1);
    chk("attention", 8'hd7, unitAttn_reg);
    readyAttn <= 1'b1;
    @(posedge mclk);
    readyAttn <= 1'b0;
    @(posedge mclk);
    chk("attention", 8'hff, unitAttn_reg);
    for (int k = 1; k < 5; k += 3) begin
      ev(2);
      ev(k);
      chk("pending", 9'h000, pendValid_reg);
      chk("attention", 8'hff, unitAttn_reg);
    end
    results;
  end
endmodule

/* tb/scsi_status_sense_tracker_checker.sv */
`timescale 1ns/1ps
`include "status_sense_defines.vh"
// Port-level relations of the status and sense tracker.
module scsi_status_sense_tracker_checker (
  input wire mclk,
  input wire reset,
  input wire reqValid,
  input wire loadingInfo,
  input wire cmdDone,
  input wire doneError,
  input wire [3:0] doneKey,
  input wire abortMsg,
  input wire abortIdValid,
  input wire [2:0] abortId,
  input wire busResetCond,
  input wire devResetMsg,
  input wire busFail,
  input wire busFailIdValid,
  input wire [2:0] busFailId,
  input wire [5:0] senseIdx,
  input wire statusValid_reg,
  input wire [7:0] statusByte_reg,
  input wire cmdSuccess_reg,
  input wire execActive_reg,
  input wire [3:0] execSlot_reg,
  input wire [7:0] senseByte_reg,
  input wire [8:0] pendValid_reg,
  input wire [7:0] unitAttn_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // A completion that counts; a reset in the same cycle drops the command instead.
  wire done = cmdDone && execActive_reg && !busResetCond && !devResetMsg;
  // Nothing in this cycle can set a pending state, so a clear shows cleanly.
  wire quiet = !reqValid && !busFail && !(cmdDone && doneError);
  stat_format_a: assert property (statusValid_reg |->
    statusByte_reg[7:5] == 3'h0 && !statusByte_reg[0]) else $error("status reserved bits set");
  busy_answer_a: assert property (reqValid && (execActive_reg || loadingInfo) && !cmdDone
    && !busResetCond && !devResetMsg |=> statusValid_reg && statusByte_reg == `ST_BUSY)
    else $error("busy not reported");
  done_check_a: assert property (done && doneError |=> statusValid_reg &&
    statusByte_reg == `ST_CHECK && pendValid_reg[execSlot_reg]) else $error("check not pending");
  done_good_a: assert property (done && !doneError |=> statusValid_reg &&
    statusByte_reg[3:0] == 4'h0 && cmdSuccess_reg) else $error("good completion wrong");
  recovered_ok_a: assert property (done && doneError && doneKey == `KEY_RECOVERED
    |=> cmdSuccess_reg) else $error("recovered error not successful");
  abort_clear_a: assert property (abortMsg && abortIdValid && quiet
    |=> !pendValid_reg[$past(abortId)]) else $error("abort left pending state");
  bus_reset_a: assert property ((busResetCond || devResetMsg) && quiet |=>
    pendValid_reg == 9'h000 && unitAttn_reg == 8'hff && !execActive_reg)
    else $error("reset did not clear state");
  bus_fail_a: assert property (busFail && !busResetCond && !devResetMsg |=>
    pendValid_reg[$past(busFailIdValid) ? {1'b0, $past(busFailId)} : 4'h8])
    else $error("bus failure not pending");
  add_len_a: assert property (senseIdx == `SB_ADDLEN && !$past(reset) |=>
    senseByte_reg == `SENSE_ADD_LEN) else $error("additional length wrong");
  err_code_a: assert property (senseIdx == `SB_ERR && !$past(reset) |=>
    senseByte_reg[6:0] == `SENSE_ERR_CODE) else $error("error code wrong");
  cover property (statusValid_reg && statusByte_reg == `ST_INTERMEDIATE);
  cover property (statusValid_reg && statusByte_reg == `ST_CONFLICT);
  cover property (pendValid_reg[8]);
endmodule
bind scsi_status_sense_tracker scsi_status_sense_tracker_checker i_chk (.mclk, .reset,
  .reqValid, .loadingInfo, .cmdDone, .doneError, .doneKey, .abortMsg, .abortIdValid,
  .abortId, .busResetCond, .devResetMsg, .busFail, .busFailIdValid, .busFailId, .senseIdx,
  .statusValid_reg, .statusByte_reg, .cmdSuccess_reg, .execActive_reg, .execSlot_reg,
  .senseByte_reg, .pendValid_reg, .unitAttn_reg);
